/* logic/sfrd_consts.svh */
// Offsets, opcodes, field positions and phase lengths of the read path
`ifndef SFRD_CONSTS_SVH
`define SFRD_CONSTS_SVH
// ----------------------------------------
// Register byte offsets and fields
// ----------------------------------------
`define SFRD_REG_CTRL 4'h0
`define SFRD_REG_STAT 4'h4
`define SFRD_REG_MEM 4'h8
`define SFRD_CTRL_WEL 0
`define SFRD_CTRL_WIP 1
`define SFRD_CTRL_4B 2
`define SFRD_CTRL_RST 3
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define SFRD_OP_EXTW 8'hc5
`define SFRD_OP_VOLWE 8'h50
`define SFRD_OP_RD3 8'h03
`define SFRD_OP_RD4 8'h13
`define SFRD_OP_FR3 8'h0b
`define SFRD_OP_FR4 8'h0c
`define SFRD_OP_DO3 8'h3b
`define SFRD_OP_DO4 8'h3c
`define SFRD_OP_QO3 8'h6b
`define SFRD_OP_QO4 8'h6c
`define SFRD_OP_DIO3 8'hbb
`define SFRD_OP_DIO4 8'hbc
`define SFRD_OP_QIO3 8'heb
`define SFRD_OP_QIO4 8'hec
`define SFRD_OP_WRAP 8'h77
`define SFRD_OP_RSTEN 8'h66
`define SFRD_OP_RST 8'h99
`define SFRD_OP_WRSR1 8'h01
`define SFRD_OP_WRSR2 8'h31
`define SFRD_OP_WRSR3 8'h11
// ----------------------------------------
// Mode key, wrap default and phase lengths in serial clocks
// ----------------------------------------
`define SFRD_MODE_KEY 2'b10
`define SFRD_WRAP_DEF 3'b001
`define SFRD_BYTE_BITS 6'h08
`define SFRD_ADDR3 6'h18
`define SFRD_ADDR4 6'h20
`define SFRD_DUMMY_SER 6'h08
`define SFRD_DUMMY_QIO 6'h04
`define SFRD_WRAP_CLKS 6'h20
`endif

/* logic/sfrd_pkg.sv */
// Types shared by the read path design files
package sfrd_pkg;
    // Command sequencer states
    typedef enum logic [8:0] {
        ST_IDLE  = 9'h001,
        ST_CMD   = 9'h002,
        ST_ADDR  = 9'h004,
        ST_MODE  = 9'h008,
        ST_DUMMY = 9'h010,
        ST_DATA  = 9'h020,
        ST_WRAPC = 9'h040,
        ST_EXTW  = 9'h080,
        ST_SKIP  = 9'h100
    } sfrd_state_e;
    typedef logic [31:0] sfrd_addr_t;
endpackage

/* logic/sfrd_mem.sv */
// Byte array with one write port and a registered read port
`timescale 1ns/1ns
`default_nettype none
module sfrd_mem #(
    parameter int AW = 8
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [AW-1:0] rd_addr_i,
    output logic [7:0] rd_data_o
);
    logic [7:0] mem_q [0:(1<<AW)-1];

    // Array write, no reset on the storage
    always_ff @(posedge sys_clk_i) begin
        if (wr_en_i) begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
    end

    // Read data always comes out of a register
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_o <= 8'h00;
        end else begin
            rd_data_o <= mem_q[rd_addr_i];
        end
    end
endmodule
`default_nettype wire

/* logic/sfrd_top.sv */
// Serial flash read command path with Avalon-MM control registers
//
// Design decisions made here: the Avalon-MM slave port and the address map.
`include "sfrd_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module sfrd_top
    import sfrd_pkg::*;
#(
    parameter int MEM_AW = 8
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic [3:0] lane_in_i,
    output logic [3:0] lane_out_o,
    output logic [3:0] lane_oe_o,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o
);
    // ----------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------
    logic cs_n_meta_ff, cs_n_sync_ff, sclk_meta_ff, sclk_sync_ff, sclk_prev_ff;
    logic [3:0] lane_meta_ff, lane_sync_ff;

    // Two flops on every pin before any logic looks at it
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cs_n_meta_ff <= 1'b1;
            cs_n_sync_ff <= 1'b1;
            sclk_meta_ff <= 1'b0;
            sclk_sync_ff <= 1'b0;
            sclk_prev_ff <= 1'b0;
            lane_meta_ff <= 4'h0;
            lane_sync_ff <= 4'h0;
        end else begin
            cs_n_meta_ff <= cs_n_i;
            cs_n_sync_ff <= cs_n_meta_ff;
            sclk_meta_ff <= sclk_i;
            sclk_sync_ff <= sclk_meta_ff;
            sclk_prev_ff <= sclk_sync_ff;
            lane_meta_ff <= lane_in_i;
            lane_sync_ff <= lane_meta_ff;
        end
    end

    wire cs_act = ~cs_n_sync_ff;
    wire rise = sclk_sync_ff & ~sclk_prev_ff;
    wire fall = ~sclk_sync_ff & sclk_prev_ff;

    // ----------------------------------------
    // Control state
    // ----------------------------------------
    sfrd_state_e st_ff, nxt_st, cmd_next;
    logic [5:0] cnt_ff, nxt_cnt;
    logic [7:0] op_ff, ext_addr_ff, dsh_ff, mem_rd;
    logic [31:0] sh_ff, nxt_sh;
    sfrd_addr_t addr_ff;
    logic [2:0] wrap_ff, dcnt_ff;
    logic vol_en_ff, vol_used_ff, cont_ff, rst_arm_ff;
    logic wel_ff, wip_ff, four_b_ff, sreset_ff, wait_ff;
    logic [3:0] lane_out_ff, lane_oe_ff;
    logic [31:0] rdata_ff;

    // Opcode decode: the byte being completed, else the stored one
    wire in_cmd = st_ff == ST_CMD;
    wire [7:0] cmd_byte = {sh_ff[6:0], lane_sync_ff[0]};
    wire [7:0] op_sel = in_cmd ? cmd_byte : op_ff;
    wire is_plain = op_sel == `SFRD_OP_RD3 || op_sel == `SFRD_OP_RD4;
    wire is_fast = op_sel == `SFRD_OP_FR3 || op_sel == `SFRD_OP_FR4;
    wire is_dout = op_sel == `SFRD_OP_DO3 || op_sel == `SFRD_OP_DO4;
    wire is_qout = op_sel == `SFRD_OP_QO3 || op_sel == `SFRD_OP_QO4;
    wire is_dio = op_sel == `SFRD_OP_DIO3 || op_sel == `SFRD_OP_DIO4;
    wire is_qio = op_sel == `SFRD_OP_QIO3 || op_sel == `SFRD_OP_QIO4;
    wire is_read = is_plain | is_fast | is_dout | is_qout | is_dio | is_qio;
    wire op_4b = op_sel == `SFRD_OP_RD4 || op_sel == `SFRD_OP_FR4
        || op_sel == `SFRD_OP_DO4 || op_sel == `SFRD_OP_QO4
        || op_sel == `SFRD_OP_DIO4 || op_sel == `SFRD_OP_QIO4;

    // Address length and phase lengths in serial clocks
    wire long_addr = four_b_ff | op_4b;
    wire [5:0] addr_bits = long_addr ? `SFRD_ADDR4 : `SFRD_ADDR3;
    wire [5:0] addr_clks = is_qio ? (addr_bits >> 2) :
        is_dio ? (addr_bits >> 1) : addr_bits;
    wire [5:0] mode_clks = is_qio ? (`SFRD_BYTE_BITS >> 2) :
        (`SFRD_BYTE_BITS >> 1);
    wire [5:0] dummy_clks = is_qio ? `SFRD_DUMMY_QIO :
        `SFRD_DUMMY_SER;
    wire io_phase = st_ff == ST_ADDR || st_ff == ST_MODE;
    wire in_phase = !(st_ff == ST_IDLE || st_ff == ST_DATA
        || st_ff == ST_SKIP);
    wire step = rise & in_phase;
    wire last = cnt_ff == 6'h01;
    wire phase_end = step & last;
    wire cmd_done = in_cmd & phase_end;
    wire spi_reset = cmd_done & rst_arm_ff & (cmd_byte == `SFRD_OP_RST);
    wire do_reset = sreset_ff | spi_reset;
    wire is_wrsr = cmd_byte == `SFRD_OP_WRSR1 || cmd_byte == `SFRD_OP_WRSR2
        || cmd_byte == `SFRD_OP_WRSR3;

    // Output lane widths and wrap section
    wire out_w4 = is_qio | is_qout;
    wire out_w2 = is_dio | is_dout;
    wire [2:0] byte_last = out_w4 ? 3'h1 : out_w2 ? 3'h3 : 3'h7;
    wire wrap_on = is_qio & ~wrap_ff[0];
    wire [7:0] wmask = (8'h08 << wrap_ff[2:1]) - 8'h01;
    wire [31:0] addr_inc = addr_ff + 32'h1;
    wire [31:0] nxt_addr = wrap_on ?
        ((addr_ff & ~{24'h0, wmask}) | (addr_inc & {24'h0, wmask})) :
        addr_inc;
    wire load = cs_act & fall & (st_ff == ST_DATA) & (dcnt_ff == 3'h0);
    wire [7:0] byte_src = (dcnt_ff == 3'h0) ? mem_rd : dsh_ff;

    // Command decode at the eighth opcode clock
    always_comb begin
        if (is_read) begin
            cmd_next = (is_plain && wip_ff) ? ST_SKIP : ST_ADDR;
        end else if (cmd_byte == `SFRD_OP_WRAP) begin
            cmd_next = ST_WRAPC;
        end else if (cmd_byte == `SFRD_OP_EXTW) begin
            cmd_next = wel_ff ? ST_EXTW : ST_SKIP;
        end else begin
            cmd_next = ST_SKIP;
        end
    end

    // Sequencer next state; select high always returns to idle
    always_comb begin
        nxt_st = st_ff;
        if (!cs_act) begin
            nxt_st = ST_IDLE;
        end else begin
            case (st_ff)
                ST_IDLE: nxt_st = cont_ff ? ST_ADDR : ST_CMD;
                ST_CMD: if (phase_end) nxt_st = cmd_next;
                ST_ADDR: if (phase_end) begin
                    nxt_st = (is_dio | is_qio) ? ST_MODE :
                        is_plain ? ST_DATA : ST_DUMMY;
                end
                ST_MODE: if (phase_end) begin
                    nxt_st = is_qio ? ST_DUMMY : ST_DATA;
                end
                ST_DUMMY: if (phase_end) nxt_st = ST_DATA;
                ST_WRAPC: if (phase_end) nxt_st = ST_SKIP;
                ST_EXTW: if (phase_end) nxt_st = ST_SKIP;
                default: nxt_st = st_ff;
            endcase
        end
    end

    // Length of the phase being entered
    always_comb begin
        case (nxt_st)
            ST_CMD: nxt_cnt = `SFRD_BYTE_BITS;
            ST_ADDR: nxt_cnt = addr_clks;
            ST_MODE: nxt_cnt = mode_clks;
            ST_DUMMY: nxt_cnt = dummy_clks;
            ST_WRAPC: nxt_cnt = `SFRD_WRAP_CLKS;
            ST_EXTW: nxt_cnt = `SFRD_BYTE_BITS;
            default: nxt_cnt = 6'h00;
        endcase
    end

    // Input shifter, MSB first, one, two or four lanes a clock
    always_comb begin
        if (io_phase && is_qio) begin
            nxt_sh = {sh_ff[27:0], lane_sync_ff};
        end else if (io_phase && is_dio) begin
            nxt_sh = {sh_ff[29:0], lane_sync_ff[1:0]};
        end else begin
            nxt_sh = {sh_ff[30:0], lane_sync_ff[0]};
        end
    end

    // ----------------------------------------
    // Sequencer registers
    // ----------------------------------------
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_ff <= ST_IDLE;
            cnt_ff <= 6'h00;
            sh_ff <= 32'h0;
            op_ff <= 8'h00;
        end else begin
            st_ff <= nxt_st;
            if (st_ff == ST_IDLE || phase_end) cnt_ff <= nxt_cnt;
            else if (step) cnt_ff <= cnt_ff - 6'h01;
            if (step) sh_ff <= nxt_sh;
            if (cmd_done) op_ff <= cmd_byte;
        end
    end

    // Start address; short addresses take the extended byte on top
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            addr_ff <= 32'h0;
        end else if (phase_end && st_ff == ST_ADDR) begin
            addr_ff <= long_addr ? nxt_sh :
                {ext_addr_ff, nxt_sh[23:0]};
        end else if (load) begin
            addr_ff <= nxt_addr;
        end
    end

    // Extended address and wrap bits; hardware set wins over reset
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ext_addr_ff <= 8'h00;
            wrap_ff <= `SFRD_WRAP_DEF;
        end else begin
            if (do_reset) ext_addr_ff <= 8'h00;
            if (do_reset) wrap_ff <= `SFRD_WRAP_DEF;
            if (phase_end && st_ff == ST_EXTW) ext_addr_ff <= nxt_sh[7:0];
            if (phase_end && st_ff == ST_WRAPC) wrap_ff <= nxt_sh[6:4];
        end
    end

    // Volatile enable, continuous mode and reset arming
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            vol_en_ff <= 1'b0;
            vol_used_ff <= 1'b0;
            cont_ff <= 1'b0;
            rst_arm_ff <= 1'b0;
        end else begin
            if (do_reset) cont_ff <= 1'b0;
            if (do_reset) vol_en_ff <= 1'b0;
            if (cmd_done) rst_arm_ff <= cmd_byte == `SFRD_OP_RSTEN;
            if (cmd_done) vol_en_ff <= cmd_byte == `SFRD_OP_VOLWE;
            if (cmd_done && is_wrsr) vol_used_ff <= vol_en_ff;
            if (phase_end && st_ff == ST_MODE) begin
                cont_ff <= nxt_sh[5:4] == `SFRD_MODE_KEY;
            end
        end
    end

    // Output shifter: load a byte at its first falling edge
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dsh_ff <= 8'h00;
            dcnt_ff <= 3'h0;
        end else if (!cs_act) begin
            dcnt_ff <= 3'h0;
        end else if (fall && st_ff == ST_DATA) begin
            dcnt_ff <= (dcnt_ff == 3'h0) ? byte_last : dcnt_ff - 3'h1;
            dsh_ff <= out_w4 ? {byte_src[3:0], 4'h0} :
                out_w2 ? {byte_src[5:0], 2'h0} : {byte_src[6:0], 1'b0};
        end
    end

    // Lane drivers change on falling edges only in the data phase
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lane_out_ff <= 4'h0;
            lane_oe_ff <= 4'h0;
        end else if (!cs_act || st_ff != ST_DATA) begin
            lane_out_ff <= 4'h0;
            lane_oe_ff <= 4'h0;
        end else if (fall) begin
            lane_out_ff <= out_w4 ? byte_src[7:4] :
                out_w2 ? {2'b00, byte_src[7:6]} :
                {2'b00, byte_src[7], 1'b0};
            lane_oe_ff <= out_w4 ? 4'hf : out_w2 ? 4'h3 : 4'h2;
        end
    end

    assign lane_out_o = lane_out_ff;
    assign lane_oe_o = lane_oe_ff;

    // ----------------------------------------
    // Avalon-MM slave: one wait state on every access
    // ----------------------------------------
    wire req = avs_read_i | avs_write_i;
    wire acc_wr = avs_write_i & ~wait_ff;
    wire sel_ctrl = avs_address_i == `SFRD_REG_CTRL;
    wire sel_stat = avs_address_i == `SFRD_REG_STAT;
    wire sel_mem = avs_address_i == `SFRD_REG_MEM;
    wire ctrl_we = acc_wr & sel_ctrl & avs_byteenable_i[0];
    wire mem_we = acc_wr & sel_mem & (&avs_byteenable_i[1:0]);
    wire [31:0] ctrl_rd = {29'h0, four_b_ff, wip_ff, wel_ff};
    wire [31:0] stat_rd = {17'h0, vol_used_ff, cs_act, cont_ff, vol_en_ff,
        wrap_ff, ext_addr_ff};
    wire [31:0] rd_mux = sel_ctrl ? ctrl_rd : sel_stat ? stat_rd : 32'h0;

    // Array loaded by software, read at the current stream address
    sfrd_mem #(
        .AW(MEM_AW)
    ) u_mem (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .wr_en_i(mem_we),
        .wr_addr_i(avs_writedata_i[8 +: MEM_AW]),
        .wr_data_i(avs_writedata_i[7:0]),
        .rd_addr_i(addr_ff[MEM_AW-1:0]),
        .rd_data_o(mem_rd)
    );

    // Handshake and read data capture
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0;
        end else begin
            wait_ff <= ~(req & wait_ff);
            if (avs_read_i && wait_ff) rdata_ff <= rd_mux;
        end
    end

    // Control bits written by software; reset bit is a pulse
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wel_ff <= 1'b0;
            wip_ff <= 1'b0;
            four_b_ff <= 1'b0;
            sreset_ff <= 1'b0;
        end else begin
            sreset_ff <= ctrl_we & avs_writedata_i[`SFRD_CTRL_RST];
            if (ctrl_we) begin
                wel_ff <= avs_writedata_i[`SFRD_CTRL_WEL];
                wip_ff <= avs_writedata_i[`SFRD_CTRL_WIP];
                four_b_ff <= avs_writedata_i[`SFRD_CTRL_4B];
            end
        end
    end

    assign avs_waitrequest_o = wait_ff;
    assign avs_readdata_o = rdata_ff;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    ext_wel_gate_a: assert property (
        cmd_done && cmd_byte == `SFRD_OP_EXTW && !wel_ff |=> st_ff == ST_SKIP)
        else $error("extended write taken without latch");
    ext_clear_a: assert property (
        do_reset && !(phase_end && st_ff == ST_EXTW) |=> ext_addr_ff == 8'h00)
        else $error("extended address not cleared by reset");
    vol_drop_a: assert property (
        cmd_done && cmd_byte != `SFRD_OP_VOLWE |=> !vol_en_ff)
        else $error("volatile enable survived another command");
    vol_set_a: assert property (
        cmd_done && cmd_byte == `SFRD_OP_VOLWE |=> vol_en_ff && $stable(wel_ff))
        else $error("volatile enable not set or latch touched");
    busy_read_a: assert property (
        cmd_done && is_plain && wip_ff |=> st_ff == ST_SKIP [*2])
        else $error("plain read accepted while busy");
    addr_step_a: assert property (
        load && !wrap_on |=> addr_ff == $past(addr_ff) + 32'h1)
        else $error("address did not step by one");
    wrap_hold_a: assert property (
        load && wrap_on |=>
        ((addr_ff ^ $past(addr_ff)) & 32'hffffffc0) == 32'h0)
        else $error("wrap left its section");
    release_hiz_a: assert property (
        !cs_act |=> lane_oe_ff == 4'h0 && st_ff == ST_IDLE)
        else $error("outputs driven after select rose");
    header_hiz_a: assert property (
        st_ff == ST_CMD || st_ff == ST_ADDR || st_ff == ST_MODE
        || st_ff == ST_DUMMY |-> lane_oe_ff == 4'h0)
        else $error("output driven during header");
    cont_skip_a: assert property (
        cs_act && st_ff == ST_IDLE && cont_ff |=> st_ff == ST_ADDR)
        else $error("continuous frame expected opcode");
    quad_lanes_a: assert property (
        load && out_w4 |=> lane_oe_ff == 4'hf)
        else $error("quad read not on four lanes");

    quad_read_c: cover property (cmd_done && is_qio);
    cont_read_c: cover property (st_ff == ST_DATA && cont_ff);
    wrap_read_c: cover property (load && wrap_on);
    ext_write_c: cover property (phase_end && st_ff == ST_EXTW);
endmodule
`default_nettype wire

/* verif/sfrd_host.sv */
// Host SPI controller model: drives select, clock and lanes
`timescale 1ns/1ns
`default_nettype none
module sfrd_host (
    input wire logic sys_clk_i,
    input wire logic [3:0] lane_i,
    input wire logic [3:0] oe_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic [3:0] lane_o,
    output logic [15:0] rx_o,
    output logic rx_vld_o
);
    logic drv = 0;
    logic [3:0] val = 0, pat = 0, hoe = 0;
    initial begin
        cs_n_o = 1;
        sclk_o = 0;
        rx_o = 0;
        rx_vld_o = 0;
    end
    // Released lanes show a toggling pattern, never the last value
    always @(posedge sys_clk_i) pat <= ~pat;
    always @(posedge sys_clk_i) if (rx_vld_o) rx_vld_o <= 0;
    assign lane_o = drv ? val : pat;
    // One serial clock: fall with new lanes, rise, sample late in high
    task automatic tick(input logic o, input logic [3:0] v);
        @(posedge sys_clk_i);
        sclk_o <= 0;
        drv <= o;
        val <= v;
        repeat (4) @(posedge sys_clk_i);
        sclk_o <= 1;
        repeat (3) @(posedge sys_clk_i);
    endtask
    task automatic open();
        @(posedge sys_clk_i);
        cs_n_o <= 0;
        hoe = 0;
        repeat (3) @(posedge sys_clk_i);
    endtask
    // Header bits MSB first, w lanes per clock
    task automatic put(input int n, input int w, input logic [31:0] d);
        for (int i = n - 1; i >= 0; i--) begin
            tick(1, 4'(d >> (i * w)) & 4'((1 << w) - 1));
            hoe = hoe | oe_i;
        end
    endtask
    // One data byte; lane_one alone carries single-lane data
    task automatic get(input int w);
        logic [7:0] sh;
        logic [3:0] oa;
        oa = 0;
        for (int i = 0; i < 8 / w; i++) begin
            tick(0, 4'h0);
            oa = oa | oe_i;
            sh = w == 1 ? {sh[6:0], lane_i[1]} :
                 w == 2 ? {sh[5:0], lane_i[1:0]} : {sh[3:0], lane_i};
        end
        rx_o <= {hoe, oa, sh};
        rx_vld_o <= 1;
    endtask
    task automatic close();
        @(posedge sys_clk_i);
        sclk_o <= 0;
        drv <= 0;
        repeat (4) @(posedge sys_clk_i);
        cs_n_o <= 1;
        repeat (8) @(posedge sys_clk_i);
    endtask
endmodule
`default_nettype wire

/* verif/serial_flash_read_command_path_test.sv */
// Self-checking bench for the serial flash read command path
`timescale 1ns/1ns
`default_nettype none
module serial_flash_read_command_path_test;
    logic clk = 0, rst_n = 0, rd = 0, wr = 0, wt, cs_n, sclk, rvld, fb = 0;
    logic [3:0] adr = 0, lout, loe, hl, lane;
    logic [31:0] wd = 0, rdat, q_e[$], q_m[$];
    logic [15:0] rx;
    logic [7:0] mem [256];
    logic [7:0] ops [12] = '{8'h03, 8'h13, 8'h0b, 8'h0c, 8'h3b, 8'h3c,
                             8'h6b, 8'h6c, 8'hbb, 8'hbc, 8'heb, 8'hec};
    int miscompares = 0, checked = 0, cyc = 0, wl = 0;
    always #50 clk = ~clk;
    assign lane = (loe & lout) | (~loe & hl);
    sfrd_top DUT (.sys_clk_i(clk), .reset_n_i(rst_n), .cs_n_i(cs_n),
        .sclk_i(sclk), .lane_in_i(lane), .lane_out_o(lout),
        .lane_oe_o(loe), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_byteenable_i(4'hf), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wt));
    sfrd_host host (.sys_clk_i(clk), .lane_i(lane), .oe_i(loe),
        .cs_n_o(cs_n), .sclk_o(sclk), .lane_o(hl), .rx_o(rx),
        .rx_vld_o(rvld));
    task automatic results();
        if (q_e.size() != 0) miscompares++;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Compare each result with the oldest note
    task automatic cmp(input logic [31:0] v);
        logic [31:0] e, m;
        e = q_e.pop_front();
        m = q_m.pop_front();
        checked++;
        if ((v & m) !== (e & m)) begin
            miscompares++;
            $display("Error at %0t: got %h want %h", $time, v, e);
        end
    endtask
    always @(posedge clk) if (rd && wt === 1'b0) cmp(rdat);
    always @(posedge clk) if (rvld === 1'b1) cmp({16'h0, rx});
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            miscompares++;
            results();
        end
    end
    task automatic ex(input logic [31:0] e, input logic [31:0] m);
        q_e.push_back(e);
        q_m.push_back(m);
    endtask
    // Avalon access held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        @(posedge clk);
        while (wt !== 1'b0) @(posedge clk);
        rd <= 0;
        wr <= 0;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] e,
                        input logic [31:0] m);
        ex(e, m);
        bus(0, a, 0);
    endtask
    task automatic cmd(input logic [7:0] op, input int n,
                       input logic [31:0] d);
        host.open();
        host.put(8, 1, op);
        host.put(n, 1, d);
        host.close();
    endtask
    // Read frame of variant k; ok low means the read must stay silent
    task automatic rdf(input int k, input logic [31:0] a, input int n,
                       input logic [7:0] md, input logic skip,
                       input logic ok);
        int j, al, dl;
        logic [3:0] mk;
        logic [31:0] ix;
        j = k / 2;
        al = j == 4 ? 2 : j == 5 ? 4 : 1;
        dl = j < 2 ? 1 : (j == 3 || j == 5) ? 4 : 2;
        mk = dl == 1 ? 4'h2 : dl == 2 ? 4'h3 : 4'hf;
        host.open();
        if (!skip) host.put(8, 1, ops[k]);
        host.put(((k % 2 == 1 || fb) ? 32 : 24) / al, al, a);
        if (j > 3) host.put(8 / al, al, md);
        host.put(j == 0 || j == 4 ? 0 : j == 5 ? 4 : 8, 1, 0);
        for (int i = 0; i < n; i++) begin
            ix = (wl != 0 && j == 5) ?
                 (a & ~(wl - 1)) | ((a + i) & (wl - 1)) : a + i;
            ex({20'h0, ok ? mk : 4'h0, mem[ix[7:0]]},
               ok ? 32'hffff : 32'hff00);
            host.get(dl);
        end
        host.close();
    endtask
    initial begin
        void'($urandom(32'h0741));
        repeat (3) @(posedge clk);
        rst_n <= 1;
        repeat (3) @(posedge clk);
        rchk(4'h4, 32'h100, 32'h5fff);
        rchk(4'hc, 0, 32'hffffffff);
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'($urandom);
            bus(1, 4'h8, {16'h0, 8'(i), mem[i]});
        end
        $display("test reset and load done");
        cmd(8'hc5, 8, 32'h5a);
        rchk(4'h4, 0, 32'hff);
        bus(1, 4'h0, 32'h1);
        cmd(8'hc5, 8, 32'h5a);
        rchk(4'h4, 32'h5a, 32'hff);
        bus(1, 4'h0, 32'h8);
        rchk(4'h4, 32'h100, 32'h7ff);
        $display("test extended address done");
        bus(1, 4'h0, 32'h1);
        cmd(8'h50, 0, 0);
        rchk(4'h0, 32'h1, 32'h1);
        rchk(4'h4, 32'h800, 32'h800);
        rdf(0, $urandom, 1, 0, 0, 1);
        rchk(4'h4, 0, 32'h800);
        cmd(8'h50, 0, 0);
        cmd(8'h01, 8, 0);
        rchk(4'h4, 32'h4000, 32'h4800);
        bus(1, 4'h0, 32'h0);
        $display("test volatile enable done");
        for (int k = 0; k < 12; k++) rdf(k, $urandom, 3, 0, 0, 1);
        bus(1, 4'h0, 32'h4);
        fb = 1;
        rdf(0, $urandom, 2, 0, 0, 1);
        bus(1, 4'h0, 32'h2);
        fb = 0;
        rdf(0, $urandom, 1, 0, 0, 0);
        bus(1, 4'h0, 32'h0);
        $display("test read variants done");
        for (int k = 8; k < 12; k += 2) begin
            rdf(k, $urandom, 2, 8'h20, 0, 1);
            rchk(4'h4, 32'h1000, 32'h1000);
            rdf(k, $urandom, 2, 8'h00, 1, 1);
            rchk(4'h4, 0, 32'h1000);
        end
        $display("test continuous mode done");
        for (int l = 0; l < 4; l++) begin
            cmd(8'h77, 32, {25'h0, 2'(l), 5'h0});
            rchk(4'h4, 32'(l) << 9, 32'h700);
            wl = 8 << l;
            rdf(10, ($urandom & ~(wl - 1)) | (wl - 2), 5, 0, 0, 1);
        end
        cmd(8'h66, 0, 0);
        cmd(8'h99, 0, 0);
        rchk(4'h4, 32'h100, 32'h17ff);
        cmd(8'h77, 32, 32'h10);
        wl = 0;
        rdf(10, 32'h3e, 4, 0, 0, 1);
        $display("test wrap done");
        repeat (4) @(posedge clk);
        results();
    end
endmodule
`default_nettype wire
